// ===== logic/plc_action_pkg.sv
// Shared constants for the logic statement action engine
package plc_action_pkg;
  // Statement store
  localparam int NUM_STMT = 16;
  localparam int STMT_IDX_W = 4;
  localparam int TIMER_W = 16;
  localparam logic [3:0] LAST_STMT = 4'hf;
  // Byte positions inside one statement word
  localparam int COND1_LSB = 24;
  localparam int OPER_LSB = 16;
  localparam int COND2_LSB = 8;
  localparam int ACTION_LSB = 0;
  // Condition codes
  localparam logic [7:0] COND_FALSE = 8'h00;
  localparam logic [7:0] COND_TRUE = 8'h01;
  localparam logic [7:0] COND_DIN_FIRST = 8'h32;
  localparam logic [7:0] COND_DIN_LAST = 8'h39;
  localparam logic [7:0] COND_VAR_FIRST = 8'h64;
  localparam logic [7:0] COND_VAR_LAST = 8'h67;
  // Logic operator codes
  localparam logic [7:0] OP_OR = 8'h00;
  localparam logic [7:0] OP_AND = 8'h01;
  localparam logic [7:0] OP_XOR = 8'h02;
  localparam logic [7:0] OP_NOR = 8'h03;
  // Action codes
  localparam logic [7:0] ACT_PRESET_SEL = 8'h18;
  localparam logic [7:0] ACT_PRESET_BIT0 = 8'h19;
  localparam logic [7:0] ACT_PRESET_BIT3 = 8'h1c;
  localparam logic [7:0] ACT_TABLE_BIT0 = 8'h23;
  localparam logic [7:0] ACT_TABLE_BIT1 = 8'h24;
  localparam logic [7:0] ACT_RELAY2 = 8'h25;
  localparam logic [7:0] ACT_TORQUE = 8'h26;
  localparam logic [7:0] ACT_VAR_A = 8'h28;
  localparam logic [7:0] ACT_VAR_D = 8'h2b;
  localparam logic [7:0] ACT_TMR_A_ZERO = 8'h32;
  localparam logic [7:0] ACT_TMR_A_PRESET = 8'h33;
  localparam logic [7:0] ACT_TMR_B_ZERO = 8'h34;
  localparam logic [7:0] ACT_TMR_B_PRESET = 8'h35;
  // Preset index that means zero speed
  localparam logic [3:0] PRESET_ZERO_IDX = 4'hf;
  // Reset values
  localparam logic [31:0] STMT_RESET = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
  // Scanner states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_COMMIT = 3'b100
  } scan_state_t;
endpackage

// ===== logic/stmt_eval_if.sv
// Bundle between the scanner and the statement evaluator
`timescale 1ns/1ps
interface stmt_eval_if;
  logic [31:0] word; // Statement under evaluation
  logic [7:0] din; // Digital inputs 1 to 8
  logic [3:0] vars; // Logical variables A to D
  logic result; // Statement result
  logic [7:0] action; // Action byte of the statement
  modport evaluator (input word, input din, input vars,
    output result, output action);
  modport scanner (output word, output din, output vars,
    input result, input action);
endinterface

// ===== logic/stmt_evaluator.sv
// Combinational evaluation of one logic statement word
`timescale 1ns/1ps
module stmt_evaluator
  import plc_action_pkg::*;
(
  // Statement and operands
  stmt_eval_if.evaluator ev
);
  logic [7:0] cond1_code; // First condition byte
  logic [7:0] oper_code; // Operator byte
  logic [7:0] cond2_code; // Second condition byte
  logic cond1; // First condition value
  logic cond2; // Second condition value

  // Unknown condition codes read as false, never as true
  function automatic logic cond_value(input logic [7:0] code,
    input logic [7:0] din, input logic [3:0] vars);
    logic val;
    val = 1'b0;
    if (code == COND_TRUE) begin
      val = 1'b1;
    end else if (code >= COND_DIN_FIRST && code <= COND_DIN_LAST) begin
      val = din[3'(code - COND_DIN_FIRST)];
    end else if (code >= COND_VAR_FIRST && code <= COND_VAR_LAST) begin
      val = vars[2'(code - COND_VAR_FIRST)];
    end
    return val;
  endfunction

  // Split the word into its four bytes
  always_comb begin
    cond1_code = ev.word[COND1_LSB +: 8];
    oper_code = ev.word[OPER_LSB +: 8];
    cond2_code = ev.word[COND2_LSB +: 8];
    ev.action = ev.word[ACTION_LSB +: 8];
  end

  // Combine both conditions
  always_comb begin
    cond1 = cond_value(cond1_code, ev.din, ev.vars);
    cond2 = cond_value(cond2_code, ev.din, ev.vars);
    case (oper_code)
      OP_OR: ev.result = cond1 | cond2;
      OP_AND: ev.result = cond1 & cond2;
      OP_XOR: ev.result = cond1 ^ cond2;
      OP_NOR: ev.result = ~(cond1 | cond2);
      default: ev.result = 1'b0;
    endcase
  end
endmodule

// ===== logic/plc_action_engine.sv
// Logic statement scanner and action side of the drive logic mode
`timescale 1ns/1ps
// How it works
// - action 36 drives table index bit 1
// - action 37 drives relay 2 when selected
// - action 38 picks torque, ignored under V/F
// - actions 40-43 write variables A-D
// - action 50 zeroes timer A when true
// - action 51 loads timer A preset
// - action 53 loads timer B preset
// - preset index 0-14 speeds, 15 zero speed
// - table index 0-3 selects tables 1-4
// - statement word is cond.op.cond.action bytes
// - NOR with false means first condition low
// - OR is true if either condition true
// - unprogrammed preset index stays zero
// - action 24 takes speed from preset table
// - actions 25-28 drive preset index bits
// - action 35 drives table index bit 0
module plc_action_engine
  import plc_action_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic plc_mode_en,
  input wire logic relay2_source_plc,
  input wire logic vf_mode,
  input wire logic [TIMER_W-1:0] timer_a_preset_count,
  input wire logic [TIMER_W-1:0] timer_b_preset_count,
  // Statement store write port
  input wire logic stmt_wr_en,
  input wire logic [STMT_IDX_W-1:0] stmt_wr_idx,
  input wire logic [31:0] stmt_wr_data,
  // Drive inputs
  input wire logic [7:0] dig_in,
  input wire logic timer_tick,
  // Speed reference selection
  output logic preset_speed_enable,
  output logic [3:0] preset_speed_index,
  output logic [14:0] preset_onehot,
  output logic zero_speed,
  // Parameter table selection
  output logic [1:0] param_table_index,
  output logic [3:0] param_table_onehot,
  // Drive control
  output logic relay2_out,
  output logic torque_mode,
  output logic [3:0] logic_vars,
  // Timers
  output logic [TIMER_W-1:0] timer_a_count,
  output logic [TIMER_W-1:0] timer_b_count,
  output logic timer_a_done,
  output logic timer_b_done,
  // Scan status
  output logic scan_done
);
  // Statement store
  logic [31:0] stmt_mem_q [NUM_STMT];
  logic [31:0] stmt_mem_d [NUM_STMT];
  // Scanner
  scan_state_t state_q, state_d;
  logic [STMT_IDX_W-1:0] idx_q, idx_d;
  // Shadow values built up during one scan
  logic shd_psel_q, shd_psel_d; // Preset/analog select
  logic [3:0] shd_pidx_q, shd_pidx_d; // Preset index
  logic [1:0] shd_tidx_q, shd_tidx_d; // Table index
  logic shd_relay_q, shd_relay_d; // Relay 2 request
  logic shd_torque_q, shd_torque_d; // Torque request
  // Variables persist across scans and update at once
  logic [3:0] vars_q, vars_d;
  // Published outputs
  logic psel_q, psel_d;
  logic [3:0] pidx_q, pidx_d;
  logic [14:0] ponehot_q, ponehot_d;
  logic zspeed_q, zspeed_d;
  logic [1:0] tidx_q, tidx_d;
  logic [3:0] tonehot_q, tonehot_d;
  logic relay_q, relay_d;
  logic torque_q, torque_d;
  logic done_q, done_d;
  // Timers
  logic [TIMER_W-1:0] tmr_q [2];
  logic [TIMER_W-1:0] tmr_d [2];
  logic [TIMER_W-1:0] tmr_preset [2];
  logic [1:0] tmr_zero; // Load-zero strobes
  logic [1:0] tmr_load; // Load-preset strobes
  // Evaluator link
  logic active; // A statement is being applied
  logic res; // Its result
  logic [7:0] act; // Its action code

  stmt_eval_if eval_bus ();

  stmt_evaluator u_eval (
    .ev(eval_bus.evaluator)
  );

  // Feed the current statement to the evaluator
  always_comb begin
    eval_bus.word = stmt_mem_q[idx_q];
    eval_bus.din = dig_in;
    eval_bus.vars = vars_q;
    res = eval_bus.result;
    act = eval_bus.action;
    active = (state_q == ST_SCAN);
  end

  // Store writes; a rewrite takes effect on the next scan of that entry
  always_comb begin
    stmt_mem_d = stmt_mem_q;
    if (stmt_wr_en) begin
      stmt_mem_d[stmt_wr_idx] = stmt_wr_data;
    end
  end

  // Scan sequencer: one statement per clock, lowest number first
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        idx_d = '0;
        if (plc_mode_en) begin
          state_d = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (idx_q == LAST_STMT) begin
          state_d = ST_COMMIT;
        end else begin
          idx_d = idx_q + 4'h1;
        end
      end
      ST_COMMIT: begin
        done_d = 1'b1;
        idx_d = '0;
        state_d = plc_mode_en ? ST_SCAN : ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        idx_d = '0;
      end
    endcase
  end

  // Apply the action of the current statement to the shadows
  always_comb begin
    shd_psel_d = shd_psel_q;
    shd_pidx_d = shd_pidx_q;
    shd_tidx_d = shd_tidx_q;
    shd_relay_d = shd_relay_q;
    shd_torque_d = shd_torque_q;
    vars_d = vars_q;
    if (state_q == ST_COMMIT || state_q == ST_IDLE) begin
      // Shadows restart cleared so unused actions read as reset
      shd_psel_d = 1'b0;
      shd_pidx_d = 4'h0;
      shd_tidx_d = 2'h0;
      shd_relay_d = 1'b0;
      shd_torque_d = 1'b0;
    end else if (active) begin
      if (act == ACT_PRESET_SEL) begin
        shd_psel_d = res;
      end
      if (act >= ACT_PRESET_BIT0 && act <= ACT_PRESET_BIT3) begin
        shd_pidx_d[2'(act - ACT_PRESET_BIT0)] = res;
      end
      if (act == ACT_TABLE_BIT0) begin
        shd_tidx_d[0] = res;
      end
      if (act == ACT_TABLE_BIT1) begin
        shd_tidx_d[1] = res;
      end
      if (act == ACT_RELAY2) begin
        shd_relay_d = res;
      end
      if (act == ACT_TORQUE) begin
        shd_torque_d = res;
      end
      if (act >= ACT_VAR_A && act <= ACT_VAR_D) begin
        // Later statements see this value on the next clock
        vars_d[2'(act - ACT_VAR_A)] = res;
      end
    end
  end

  // Publish the finished scan in one step so outputs never glitch
  always_comb begin
    psel_d = psel_q;
    pidx_d = pidx_q;
    ponehot_d = ponehot_q;
    zspeed_d = zspeed_q;
    tidx_d = tidx_q;
    tonehot_d = tonehot_q;
    relay_d = relay_q;
    torque_d = torque_q;
    if (state_q == ST_COMMIT) begin
      psel_d = shd_psel_q;
      pidx_d = shd_pidx_q;
      zspeed_d = (shd_pidx_q == PRESET_ZERO_IDX);
      ponehot_d = 15'h0000;
      if (shd_pidx_q != PRESET_ZERO_IDX) begin
        ponehot_d[shd_pidx_q] = 1'b1;
      end
      tidx_d = shd_tidx_q;
      tonehot_d = 4'h1 << shd_tidx_q;
      relay_d = shd_relay_q & relay2_source_plc;
      torque_d = shd_torque_q & ~vf_mode;
    end else if (state_q == ST_IDLE) begin
      // Outside logic mode the published outputs rest at defaults; variables hold
      psel_d = 1'b0;
      pidx_d = 4'h0;
      ponehot_d = 15'h0001;
      zspeed_d = 1'b0;
      tidx_d = 2'h0;
      tonehot_d = 4'h1;
      relay_d = 1'b0;
      torque_d = 1'b0;
    end
    // Mode inputs gate at once, not only at the next commit
    if (!relay2_source_plc) begin
      relay_d = 1'b0;
    end
    if (vf_mode) begin
      torque_d = 1'b0;
    end
  end

  // Timer load strobes from the action under evaluation
  always_comb begin
    tmr_zero[0] = active && res && act == ACT_TMR_A_ZERO;
    tmr_load[0] = active && res && act == ACT_TMR_A_PRESET;
    tmr_zero[1] = active && res && act == ACT_TMR_B_ZERO;
    tmr_load[1] = active && res && act == ACT_TMR_B_PRESET;
    tmr_preset[0] = timer_a_preset_count;
    tmr_preset[1] = timer_b_preset_count;
  end

  // Timers: a load beats a tick in the same clock
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    always_comb begin
      tmr_d[t] = tmr_q[t];
      if (tmr_zero[t]) begin
        tmr_d[t] = TIMER_RESET;
      end else if (tmr_load[t]) begin
        tmr_d[t] = tmr_preset[t];
      end else if (timer_tick && tmr_q[t] < tmr_preset[t]) begin
        tmr_d[t] = tmr_q[t] + 16'h0001;
      end
    end
  end

  // Register every group
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_STMT; i++) begin
        stmt_mem_q[i] <= STMT_RESET;
      end
      state_q <= ST_IDLE;
      idx_q <= '0;
      shd_psel_q <= 1'b0;
      shd_pidx_q <= 4'h0;
      shd_tidx_q <= 2'h0;
      shd_relay_q <= 1'b0;
      shd_torque_q <= 1'b0;
      vars_q <= 4'h0;
      psel_q <= 1'b0;
      pidx_q <= 4'h0;
      ponehot_q <= 15'h0001;
      zspeed_q <= 1'b0;
      tidx_q <= 2'h0;
      tonehot_q <= 4'h1;
      relay_q <= 1'b0;
      torque_q <= 1'b0;
      done_q <= 1'b0;
      tmr_q[0] <= TIMER_RESET;
      tmr_q[1] <= TIMER_RESET;
    end else begin
      stmt_mem_q <= stmt_mem_d;
      state_q <= state_d;
      idx_q <= idx_d;
      shd_psel_q <= shd_psel_d;
      shd_pidx_q <= shd_pidx_d;
      shd_tidx_q <= shd_tidx_d;
      shd_relay_q <= shd_relay_d;
      shd_torque_q <= shd_torque_d;
      vars_q <= vars_d;
      psel_q <= psel_d;
      pidx_q <= pidx_d;
      ponehot_q <= ponehot_d;
      zspeed_q <= zspeed_d;
      tidx_q <= tidx_d;
      tonehot_q <= tonehot_d;
      relay_q <= relay_d;
      torque_q <= torque_d;
      done_q <= done_d;
      tmr_q <= tmr_d;
    end
  end

  // Output wiring
  always_comb begin
    preset_speed_enable = psel_q;
    preset_speed_index = pidx_q;
    preset_onehot = ponehot_q;
    zero_speed = zspeed_q;
    param_table_index = tidx_q;
    param_table_onehot = tonehot_q;
    relay2_out = relay_q;
    torque_mode = torque_q;
    logic_vars = vars_q;
    timer_a_count = tmr_q[0];
    timer_b_count = tmr_q[1];
    timer_a_done = (tmr_q[0] == timer_a_preset_count);
    timer_b_done = (tmr_q[1] == timer_b_preset_count);
    scan_done = done_q;
  end

  // Checks on the published values
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_TABLE_ONEHOT: assert property (
    state_q == ST_COMMIT |=> param_table_onehot == (4'h1 << $past(shd_tidx_q))
  ) else $error("table one-hot does not match index");

  AST_PRESET_ZERO: assert property (
    state_q == ST_COMMIT && shd_pidx_q == PRESET_ZERO_IDX
      |=> zero_speed && preset_onehot == 15'h0000
  ) else $error("index 15 did not select zero speed");

  AST_TABLE_BITS: assert property (
    state_q == ST_COMMIT |=> param_table_index == $past(shd_tidx_q)
  ) else $error("table index not published at commit");

  AST_RELAY_GATE: assert property (
    !relay2_source_plc |=> !relay2_out
  ) else $error("relay 2 driven while not under logic control");

  AST_TORQUE_VF: assert property (
    vf_mode |=> !torque_mode
  ) else $error("torque mode under V/F control");

  AST_VAR_WRITE: assert property (
    active && act == ACT_VAR_A |=> logic_vars[0] == $past(res)
  ) else $error("variable A not written by its action");

  AST_TMR_A_ZERO: assert property (
    tmr_zero[0] |=> timer_a_count == TIMER_RESET
  ) else $error("timer A not zeroed");

  AST_TMR_A_LOAD: assert property (
    tmr_load[0] |=> timer_a_count == $past(timer_a_preset_count)
  ) else $error("timer A not loaded with preset");

  AST_TMR_B_ZERO: assert property (
    tmr_zero[1] |=> timer_b_count == TIMER_RESET
  ) else $error("timer B not zeroed");

  AST_TMR_B_LOAD: assert property (
    tmr_load[1] |=> timer_b_count == $past(timer_b_preset_count)
  ) else $error("timer B not loaded with preset");

  AST_SCAN_ORDER: assert property (
    state_q == ST_SCAN && idx_q != LAST_STMT |=> idx_q == $past(idx_q) + 4'h1
  ) else $error("statements not scanned in order");

  AST_TMR_HOLD: assert property (
    timer_a_done && !tmr_zero[0] && !tmr_load[0]
      && $stable(timer_a_preset_count) |=> $stable(timer_a_count)
  ) else $error("timer A moved past its preset");
endmodule

// ===== bench/drive_side_model.sv
// Far-side model: digital input levels and timer tick strobe
`timescale 1ns/1ps
module drive_side_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [7:0] din_req,
  input wire logic tick_req,
  // Levels seen by the engine
  output logic [7:0] dig_in,
  output logic timer_tick
);
  // Defined levels from time zero
  initial begin
    dig_in = 8'h00;
    timer_tick = 1'b0;
  end
  // Change on the falling edge, clear of the sampling edge
  always @(negedge ref_clk) begin
    dig_in <= din_req;
    // No ticks while the drive is held in reset
    timer_tick <= tick_req & rst_n;
  end
endmodule

// ===== bench/drive_logic_statement_actions_tb.sv
// Self-checking bench for the logic statement action engine
`timescale 1ns/1ps
module drive_logic_statement_actions_tb;
  import plc_action_pkg::*;
  // One table row: word, inputs, expected outputs
  typedef struct {
    logic [31:0] w;
    logic [7:0] d;
    logic [3:0] i;
    logic [1:0] t;
    logic r;
    logic q;
    logic [3:0] v;
  } row_t;
  // Stimulus and observed signals
  logic ref_clk, rst_n, plc_mode_en, relay2_source_plc, vf_mode;
  logic [15:0] ta_pre, tb_pre, ta_cnt, tb_cnt;
  logic stmt_wr_en, timer_tick, tick_req, ta_done, tb_done, scan_done;
  logic [3:0] stmt_wr_idx, psi, pto, vars;
  logic [31:0] stmt_wr_data;
  logic [7:0] dig_in, din_req;
  logic pse, zs, relay, torque;
  logic [14:0] pso;
  logic [1:0] pti;
  int err_count = 0;
  int samples_checked = 0;
  // Words are cond1.op.cond2.action bytes
  row_t rows[17] = '{
    '{32'h0100_0024, 8'h00, 4'h0, 2'h2, 1'h0, 1'h0, 4'h0},
    '{32'h3200_0025, 8'h01, 4'h0, 2'h0, 1'h1, 1'h0, 4'h0},
    '{32'h3200_0025, 8'h00, 4'h0, 2'h0, 1'h0, 1'h0, 4'h0},
    '{32'h0100_0026, 8'h00, 4'h0, 2'h0, 1'h0, 1'h1, 4'h0},
    '{32'h3903_0028, 8'h00, 4'h0, 2'h0, 1'h0, 1'h0, 4'h1},
    '{32'h3903_0029, 8'h00, 4'h0, 2'h0, 1'h0, 1'h0, 4'h3},
    '{32'h3903_002a, 8'h00, 4'h0, 2'h0, 1'h0, 1'h0, 4'h7},
    '{32'h3903_002b, 8'h00, 4'h0, 2'h0, 1'h0, 1'h0, 4'hf},
    '{32'h3903_0028, 8'h80, 4'h0, 2'h0, 1'h0, 1'h0, 4'he},
    '{32'h0100_0019, 8'h00, 4'h1, 2'h0, 1'h0, 1'h0, 4'he},
    '{32'h0100_001a, 8'h00, 4'h2, 2'h0, 1'h0, 1'h0, 4'he},
    '{32'h0100_001b, 8'h00, 4'h4, 2'h0, 1'h0, 1'h0, 4'he},
    '{32'h0100_001c, 8'h00, 4'h8, 2'h0, 1'h0, 1'h0, 4'he},
    '{32'h0100_0023, 8'h00, 4'h0, 2'h1, 1'h0, 1'h0, 4'he},
    '{32'h0000_0124, 8'h00, 4'h0, 2'h2, 1'h0, 1'h0, 4'he},
    // AND and XOR with both inputs high: only AND is true
    '{32'h3201_3328, 8'h03, 4'h0, 2'h0, 1'h0, 1'h0, 4'hf},
    '{32'h3202_3328, 8'h03, 4'h0, 2'h0, 1'h0, 1'h0, 4'he}};
  // Timer steps: inputs and expected counts
  logic [7:0] t_din[4] = '{8'h01, 8'h04, 8'h08, 8'h02};
  logic [15:0] t_a[4] = '{16'h0000, 16'h0000, 16'h0005, 16'h0005};
  logic [15:0] t_b[4] = '{16'h0007, 16'h0000, 16'h0000, 16'h0007};

  // Engine under test
  plc_action_engine dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .plc_mode_en(plc_mode_en), .relay2_source_plc(relay2_source_plc),
    .vf_mode(vf_mode), .timer_a_preset_count(ta_pre),
    .timer_b_preset_count(tb_pre), .stmt_wr_en(stmt_wr_en),
    .stmt_wr_idx(stmt_wr_idx), .stmt_wr_data(stmt_wr_data),
    .dig_in(dig_in), .timer_tick(timer_tick),
    .preset_speed_enable(pse), .preset_speed_index(psi),
    .preset_onehot(pso), .zero_speed(zs), .param_table_index(pti),
    .param_table_onehot(pto), .relay2_out(relay), .torque_mode(torque),
    .logic_vars(vars), .timer_a_count(ta_cnt), .timer_b_count(tb_cnt),
    .timer_a_done(ta_done), .timer_b_done(tb_done),
    .scan_done(scan_done));
  // Digital inputs and ticks come from the far-side model
  drive_side_model far (.ref_clk(ref_clk), .rst_n(rst_n),
    .din_req(din_req), .tick_req(tick_req), .dig_in(dig_in),
    .timer_tick(timer_tick));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Compare one value and count it
  task check(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Store one statement word, one-cycle strobe
  task put(input logic [3:0] idx, input logic [31:0] w);
    @(negedge ref_clk);
    stmt_wr_en <= 1'b1;
    stmt_wr_idx <= idx;
    stmt_wr_data <= w;
    @(negedge ref_clk);
    stmt_wr_en <= 1'b0;
  endtask

  // Wait for n scan completions, bounded
  task scans(input int n);
    int k;
    repeat (n) begin
      k = 0;
      @(negedge ref_clk);
      while (scan_done !== 1'b1 && k < 40) begin
        k++;
        @(negedge ref_clk);
      end
      // Missing pulse counts as a mismatch
      if (k >= 40) check("scan_done", 32'h0, 32'h1);
    end
  endtask

  // Compare all published selection and control outputs
  task outs(input logic e, input logic [3:0] i, input logic [1:0] t,
            input logic r, input logic q, input logic [3:0] v);
    check("preset_speed_enable", pse, e);
    check("preset_speed_index", psi, i);
    check("preset_onehot", pso, (i == 4'hf) ? 15'h0 : 15'h1 << i);
    check("zero_speed", zs, i == 4'hf);
    check("param_table_index", pti, t);
    check("param_table_onehot", pto, 4'h1 << t);
    check("relay2_out", relay, r);
    check("torque_mode", torque, q);
    check("logic_vars", vars, v);
  endtask

  // Single exit for pass, fail and timeout
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run of under 1000 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_count++;
    $display("watchdog expired");
    tally_and_finish;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    plc_mode_en = 1'b0;
    relay2_source_plc = 1'b1;
    vf_mode = 1'b0;
    ta_pre = 16'h0005;
    tb_pre = 16'h0007;
    stmt_wr_en = 1'b0;
    stmt_wr_idx = 4'h0;
    stmt_wr_data = 32'h0;
    din_req = 8'h00;
    tick_req = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n <= 1'b1;
    plc_mode_en <= 1'b1;
    // Table of single-statement cases in slot 0
    foreach (rows[n]) begin
      din_req <= rows[n].d;
      put(4'h0, rows[n].w);
      scans(2);
      outs(1'b0, rows[n].i, rows[n].t, rows[n].r, rows[n].q, rows[n].v);
    end
    $display("test table done");
    // Second reset mid-scan: store, variables and timers cleared
    rst_n <= 1'b0;
    repeat (5) @(negedge ref_clk);
    outs(1'b0, 4'h0, 2'h0, 1'h0, 1'h0, 4'h0);
    check("timer_a_count", ta_cnt, 16'h0);
    check("scan_done", scan_done, 1'h0);
    rst_n <= 1'b1;
    $display("test reset done");
    // Index 15 plus a variable used later in the same scan, then cleared
    for (int k = 1; k <= 4; k++) put(4'(k), 32'h0100_0018 + k);
    put(4'h5, 32'h3200_0028);
    put(4'h6, 32'h6400_0025);
    put(4'h7, 32'h0100_0018);
    put(4'h8, 32'h0000_0028);
    din_req <= 8'h01;
    scans(2);
    outs(1'b1, 4'hf, 2'h0, 1'h1, 1'h0, 4'h0);
    for (int k = 0; k <= 8; k++) put(4'(k), 32'h0);
    $display("test order done");
    // Timers: run to preset, then zero and preload by inputs
    put(4'h0, 32'h3200_0032);
    put(4'h1, 32'h3300_0035);
    put(4'h2, 32'h3400_0034);
    put(4'h3, 32'h3500_0033);
    din_req <= 8'h00;
    tick_req <= 1'b1;
    repeat (10) @(negedge ref_clk);
    tick_req <= 1'b0;
    scans(2);
    check("timer_a_count", ta_cnt, 16'h0005);
    check("timer_b_count", tb_cnt, 16'h0007);
    check("timer_done", {ta_done, tb_done}, 2'h3);
    foreach (t_din[n]) begin
      din_req <= t_din[n];
      scans(2);
      check("timer_a_count", ta_cnt, t_a[n]);
      check("timer_b_count", tb_cnt, t_b[n]);
    end
    for (int k = 0; k <= 3; k++) put(4'(k), 32'h0);
    $display("test timers done");
    // Torque ignored under V/F, relay needs logic-mode source
    relay2_source_plc <= 1'b0;
    vf_mode <= 1'b1;
    put(4'h0, 32'h0100_0026);
    put(4'h1, 32'h0100_0025);
    scans(2);
    check("torque_mode", torque, 1'h0);
    check("relay2_out", relay, 1'h0);
    $display("test gating done");
    // Leaving logic mode returns the published outputs to defaults; variables hold
    plc_mode_en <= 1'b0;
    repeat (20) @(negedge ref_clk);
    outs(1'b0, 4'h0, 2'h0, 1'h0, 1'h0, 4'h0);
    $display("test idle done");
    tally_and_finish;
  end
endmodule
